//--- src/bwpm_pkg.sv
// Constants and types for the board wake and power manager
package bwpm_pkg;
    localparam int CLK_HZ         = 20_000_000;
    localparam int SHORT_PRESS_MS = 4000;
    localparam int LONG_PRESS_MS  = 6000;
    localparam int BLINK_HALF_MS  = 500;
    localparam int SHORT_PRESS_CYC = SHORT_PRESS_MS * (CLK_HZ / 1000);
    localparam int LONG_PRESS_CYC  = LONG_PRESS_MS * (CLK_HZ / 1000);
    localparam int BLINK_HALF_CYC  = BLINK_HALF_MS * (CLK_HZ / 1000);
    localparam int PWM_BITS        = 8;
    localparam int SRC_BITS        = 4;

    typedef enum logic [1:0] {
        BWPM_S0,
        BWPM_S3,
        BWPM_S4,
        BWPM_S5
    } bwpm_state_t;

    // Wake source codes reported to firmware
    localparam logic [3:0] SRC_NONE  = 4'h0;
    localparam logic [3:0] SRC_PWRSW = 4'h1;
    localparam logic [3:0] SRC_RTC   = 4'h2;
    localparam logic [3:0] SRC_LAN   = 4'h3;
    localparam logic [3:0] SRC_USB   = 4'h4;
    localparam logic [3:0] SRC_PME   = 4'h5;
    localparam logic [3:0] SRC_WAKE  = 4'h6;
    localparam logic [3:0] SRC_SER   = 4'h7;
    localparam logic [3:0] SRC_KBD   = 4'h8;
endpackage

//--- src/bwpm_top.sv
// Board power-state sequencer with wake sources, fans and indicators
`timescale 1ns/1ps
// Contract
// - In S0 every fan output is PWM driven at the FAN_DUTY setting.
// - In S3, S4 or S5 every fan output is off.
// - Each fan has a tach input and a PWM control output.
// - LAN wake request powers the system up.
// - USB activity wakes only from S3.
// - PME line wakes from S3/S4/S5 when its enable is on.
// - PCIe wake line wakes from S3/S4/S5 unconditionally.
// - Serial activity wakes only from S3.
// - Any key wakes from S3; only combo or power key from S4/S5.
// - Armed RTC alarm wakes from soft-off.
// - Rail fault forces immediate power-down.
// - Rail fault lights the red warning output.
// - Rail fault record survives power-down until firmware clears it.
// - Standby LED lit on standby; blinks from boot start to video after a power-switch wake.
// - In S3 power LED is amber or off for single colour.
// - In S0 short press sleeps, press over six seconds forces off.
module bwpm_top
    import bwpm_pkg::*;
#(
    parameter int NFAN        = 3,
    parameter int SHORT_CYC   = SHORT_PRESS_CYC,
    parameter int LONG_CYC    = LONG_PRESS_CYC,
    parameter int BLINK_CYC   = BLINK_HALF_CYC
)(
    input  wire logic              REF_CLK,
    input  wire logic              SYS_RST,
    input  wire logic              PWR_SW_N,
    input  wire logic              LAN_WAKE_N,
    input  wire logic              USB_ACT,
    input  wire logic              PME_N,
    input  wire logic              PCIE_WAKE_N,
    input  wire logic              SER_ACT,
    input  wire logic              KBD_ACT,
    input  wire logic              KBD_PWR_KEY,
    input  wire logic              RTC_ALARM,
    input  wire logic              RAIL_FAULT,
    input  wire logic [NFAN-1:0]   FAN_TACH,
    input  wire logic              PME_WAKE_EN,
    input  wire logic              RTC_ARMED,
    input  wire logic              SLEEP_REQ,
    input  wire logic              SLEEP_S4,
    input  wire logic              BOOT_START,
    input  wire logic              VIDEO_DONE,
    input  wire logic              FAULT_CLR,
    input  wire logic              LED_DUAL,
    input  wire logic [PWM_BITS-1:0] FAN_DUTY,
    output logic [NFAN-1:0]        FAN_PWM,
    output logic [NFAN-1:0]        FAN_TACH_SEEN,
    output logic                   PS_ON,
    output logic                   RED_LED,
    output logic                   STBY_LED,
    output logic                   PWR_LED_GREEN,
    output logic                   PWR_LED_AMBER,
    output logic                   FAULT_REC,
    output logic [SRC_BITS-1:0]    WAKE_SRC
);
    import bwpm_pkg::*;

    if (NFAN < 1 || SHORT_CYC < 1 || LONG_CYC <= SHORT_CYC ||
        BLINK_CYC < 1)
    begin : g_bad_param
        $error("bwpm_top: illegal parameters");
    end

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    localparam int NSYNC = 11 + NFAN;
    logic [NSYNC-1:0] s1_r;
    logic [NSYNC-1:0] s2_r;
    logic [NSYNC-1:0] raw;
    assign raw = {FAN_TACH, ~PWR_SW_N, ~LAN_WAKE_N, USB_ACT, ~PME_N,
                  ~PCIE_WAKE_N, SER_ACT, KBD_ACT, KBD_PWR_KEY, RTC_ALARM,
                  RAIL_FAULT, BOOT_START};
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            s1_r <= '0;
            s2_r <= '0;
        end
        else
        begin
            s1_r <= raw;
            s2_r <= s1_r;
        end
    end
    logic [NFAN-1:0] tach_s;
    logic sw_s, lan_s, usb_s, pme_s, pcie_s, ser_s, kbd_s, pkey_s;
    logic rtc_s, fault_s, boot_s;
    assign {tach_s, sw_s, lan_s, usb_s, pme_s, pcie_s, ser_s, kbd_s,
            pkey_s, rtc_s, fault_s, boot_s} = s2_r;

    ////////////////////////////////////////////////////////////////////////
    // Power state machine
    bwpm_state_t st_r, st_nxt;
    logic [31:0] press_r, press_nxt;
    logic sw_d_r, sw_d_nxt;
    logic long_done_r, long_done_nxt;
    logic fault_r, fault_nxt;
    logic [SRC_BITS-1:0] src_r, src_nxt;
    logic wake;
    logic [SRC_BITS-1:0] wsrc;
    logic sleeping;
    assign sleeping = (st_r != BWPM_S0);

    // Later tests override earlier ones: lowest priority first
    always_comb
    begin
        wsrc = SRC_NONE;
        if (sleeping)
        begin
            if (kbd_s && (st_r == BWPM_S3 || pkey_s))
                wsrc = SRC_KBD;
            if (ser_s && st_r == BWPM_S3)
                wsrc = SRC_SER;
            if (usb_s && st_r == BWPM_S3)
                wsrc = SRC_USB;
            if (pme_s && PME_WAKE_EN)
                wsrc = SRC_PME;
            if (pcie_s)
                wsrc = SRC_WAKE;
            if (lan_s)
                wsrc = SRC_LAN;
            if (rtc_s && RTC_ARMED && st_r == BWPM_S5)
                wsrc = SRC_RTC;
            if (sw_d_r && !sw_s && press_r < 32'(SHORT_CYC))
                wsrc = SRC_PWRSW;
        end
        wake = (wsrc != SRC_NONE);
    end

    always_comb
    begin
        st_nxt = st_r;
        sw_d_nxt = sw_s;
        press_nxt = sw_s ? ((press_r == 32'hFFFFFFFF) ? press_r
                            : press_r + 32'h1) : 32'h0;
        long_done_nxt = sw_s ? long_done_r : 1'b0;
        fault_nxt = fault_r;
        src_nxt = src_r;
        if (fault_s)
            fault_nxt = 1'b1;
        else if (FAULT_CLR)
            fault_nxt = 1'b0;
        if (fault_s)
            st_nxt = BWPM_S5;
        else if (sw_s && press_r >= 32'(LONG_CYC) && !long_done_r)
        begin
            st_nxt = BWPM_S5;
            long_done_nxt = 1'b1;
        end
        else if (st_r == BWPM_S0)
        begin
            if (sw_d_r && !sw_s && press_r < 32'(SHORT_CYC) && !long_done_r)
                st_nxt = BWPM_S3;
            else if (SLEEP_REQ)
                st_nxt = SLEEP_S4 ? BWPM_S4 : BWPM_S3;
        end
        else if (wake && !long_done_r)
        begin
            st_nxt = BWPM_S0;
            src_nxt = wsrc;
        end
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            st_r <= BWPM_S5;
            press_r <= 32'h0;
            sw_d_r <= 1'b0;
            long_done_r <= 1'b0;
            fault_r <= 1'b0;
            src_r <= SRC_NONE;
        end
        else
        begin
            st_r <= st_nxt;
            press_r <= press_nxt;
            sw_d_r <= sw_d_nxt;
            long_done_r <= long_done_nxt;
            fault_r <= fault_nxt;
            src_r <= src_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fans, PWM and standby blink
    logic [PWM_BITS-1:0] pwm_cnt_r, pwm_cnt_nxt;
    logic [31:0] blk_cnt_r, blk_cnt_nxt;
    logic blk_ph_r, blk_ph_nxt;
    logic boot_r, boot_nxt;
    logic [NFAN-1:0] tach_d_r;
    logic [NFAN-1:0] seen_r, seen_nxt;
    logic [NFAN-1:0] pwm_nxt;

    always_comb
    begin
        pwm_cnt_nxt = pwm_cnt_r + 1'b1;
        blk_cnt_nxt = blk_cnt_r + 32'h1;
        blk_ph_nxt = blk_ph_r;
        if (blk_cnt_r >= 32'(BLINK_CYC - 1))
        begin
            blk_cnt_nxt = 32'h0;
            blk_ph_nxt = ~blk_ph_r;
        end
        boot_nxt = boot_r;
        if (st_r != BWPM_S0 || VIDEO_DONE)
            boot_nxt = 1'b0;
        else if (boot_s && src_r == SRC_PWRSW)
            boot_nxt = 1'b1;
        for (int i = 0; i < NFAN; i++)
        begin
            pwm_nxt[i] = (st_nxt == BWPM_S0) &&
                         (FAN_DUTY == '1 || pwm_cnt_nxt < FAN_DUTY);
            seen_nxt[i] = seen_r[i] | (tach_s[i] & ~tach_d_r[i]);
        end
        if (st_nxt != BWPM_S0)
            seen_nxt = '0;
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            pwm_cnt_r <= '0;
            blk_cnt_r <= 32'h0;
            blk_ph_r <= 1'b0;
            boot_r <= 1'b0;
            tach_d_r <= '0;
            seen_r <= '0;
            FAN_PWM <= '0;
            FAN_TACH_SEEN <= '0;
            PS_ON <= 1'b0;
            RED_LED <= 1'b0;
            STBY_LED <= 1'b0;
            PWR_LED_GREEN <= 1'b0;
            PWR_LED_AMBER <= 1'b0;
            FAULT_REC <= 1'b0;
            WAKE_SRC <= SRC_NONE;
        end
        else
        begin
            pwm_cnt_r <= pwm_cnt_nxt;
            blk_cnt_r <= blk_cnt_nxt;
            blk_ph_r <= blk_ph_nxt;
            boot_r <= boot_nxt;
            tach_d_r <= tach_s;
            seen_r <= seen_nxt;
            FAN_PWM <= pwm_nxt;
            FAN_TACH_SEEN <= seen_nxt;
            PS_ON <= (st_nxt == BWPM_S0);
            RED_LED <= fault_nxt;
            STBY_LED <= boot_nxt ? blk_ph_nxt : 1'b1;
            PWR_LED_GREEN <= (st_nxt == BWPM_S0);
            PWR_LED_AMBER <= (st_nxt == BWPM_S3) && LED_DUAL;
            FAULT_REC <= fault_nxt;
            WAKE_SRC <= src_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);

    fan_off_a: assert property (!PS_ON |-> FAN_PWM == '0)
        else $error("fans on while asleep");
    fault_down_a: assert property (fault_s |-> ##1 st_r == BWPM_S5)
        else $error("fault did not power down");
    fault_led_a: assert property (fault_s |=> RED_LED && FAULT_REC)
        else $error("fault not flagged");
    fault_hold_a: assert property (FAULT_REC && !FAULT_CLR |=> FAULT_REC)
        else $error("fault record lost");
    usb_s3_a: assert property (st_r == BWPM_S4 && usb_s && !pcie_s && !lan_s
        && !(pme_s && PME_WAKE_EN) && !kbd_s && !sw_d_r |=> st_r != BWPM_S0)
        else $error("usb woke from S4");
    pcie_wake_a: assert property (sleeping && pcie_s && !fault_s
        && !long_done_r && !(sw_s && press_r >= 32'(LONG_CYC))
        |=> st_r == BWPM_S0)
        else $error("pcie wake ignored");
    amber_s3_a: assert property (PWR_LED_AMBER ==
        (st_r == BWPM_S3 && $past(LED_DUAL)))
        else $error("amber indicator wrong for state");
    ps_on_a: assert property (st_r == BWPM_S0 && $past(FAN_DUTY) == '1
        |-> PS_ON && FAN_PWM == '1)
        else $error("supply or fans off in S0");
    src_hold_a: assert property (st_r == BWPM_S0 && $stable(st_r)
        |=> $stable(src_r))
        else $error("wake source changed in S0");

    c_s3_c: cover property (st_r == BWPM_S3 ##1 st_r == BWPM_S0);
    c_fault_c: cover property (fault_s ##1 st_r == BWPM_S5);
    c_rtc_c: cover property (src_r == SRC_RTC);
    c_long_c: cover property (long_done_r);
endmodule

//--- verif/bwpm_partner.sv
// Far-side model: network wake source and fans with tach feedback
`timescale 1ns/1ps
module bwpm_partner #(
    parameter int NFAN = 3
)(
    input  wire logic            clk,
    input  wire logic            lan_frame,
    input  wire logic [NFAN-1:0] fan_pwm,
    output logic                 lan_wake_n,
    output logic [NFAN-1:0]      fan_tach
);
    // Network side pulls its wake line low on a wake frame
    assign lan_wake_n = ~lan_frame;
    initial fan_tach = '0;
    // Spinning fan toggles its tach, a stopped fan holds it
    always @(posedge clk)
    begin
        fan_tach <= fan_tach ^ fan_pwm;
    end
endmodule

//--- verif/bwpm_top_tb.sv
// Self-checking bench for the board wake and power manager
`timescale 1ns/1ps
module bwpm_top_tb;
    import bwpm_pkg::*;
    localparam int NF = 3;
    localparam int LONG = 40;
    logic          clk = 1'b0, rst = 1'b1, pwr_sw_n = 1'b1, lan_frame = 1'b0;
    logic          usb = 1'b0, pme_n = 1'b1, pcie_n = 1'b1, ser = 1'b0;
    logic          kbd = 1'b0, kbd_key = 1'b0, rtc = 1'b0, fault = 1'b0;
    logic          pme_en = 1'b0, rtc_armed = 1'b0, slp = 1'b0, s4 = 1'b0;
    logic          boot = 1'b0, video = 1'b0, fclr = 1'b0, dual = 1'b1;
    logic [7:0]    duty = 8'hFF;
    logic          lan_n, ps_on, red, stby, green, amber, rec;
    logic [NF-1:0] tach, fan_pwm, seen;
    logic [3:0]    src;
    int            err_total = 0;
    int            check_count = 0;

    always #25 clk = ~clk;

    bwpm_top #(.NFAN(NF), .SHORT_CYC(20), .LONG_CYC(LONG), .BLINK_CYC(4))
    u_dut (
        .REF_CLK(clk), .SYS_RST(rst), .PWR_SW_N(pwr_sw_n),
        .LAN_WAKE_N(lan_n), .USB_ACT(usb), .PME_N(pme_n),
        .PCIE_WAKE_N(pcie_n), .SER_ACT(ser), .KBD_ACT(kbd),
        .KBD_PWR_KEY(kbd_key), .RTC_ALARM(rtc), .RAIL_FAULT(fault),
        .FAN_TACH(tach), .PME_WAKE_EN(pme_en), .RTC_ARMED(rtc_armed),
        .SLEEP_REQ(slp), .SLEEP_S4(s4), .BOOT_START(boot),
        .VIDEO_DONE(video), .FAULT_CLR(fclr), .LED_DUAL(dual),
        .FAN_DUTY(duty), .FAN_PWM(fan_pwm), .FAN_TACH_SEEN(seen),
        .PS_ON(ps_on), .RED_LED(red), .STBY_LED(stby),
        .PWR_LED_GREEN(green), .PWR_LED_AMBER(amber), .FAULT_REC(rec),
        .WAKE_SRC(src)
    );

    bwpm_partner #(.NFAN(NF)) u_far (
        .clk(clk), .lan_frame(lan_frame), .fan_pwm(fan_pwm),
        .lan_wake_n(lan_n), .fan_tach(tach)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string m);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    task automatic chk_vec(input logic [3:0] got, input logic [3:0] exp,
                           input string m);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic set_src(input logic [3:0] c, input logic on);
        case (c)
            SRC_PWRSW: pwr_sw_n = ~on;
            SRC_RTC:   rtc = on;
            SRC_LAN:   lan_frame = on;
            SRC_USB:   usb = on;
            SRC_PME:   pme_n = ~on;
            SRC_WAKE:  pcie_n = ~on;
            SRC_SER:   ser = on;
            default:   kbd = on;
        endcase
    endtask

    // Drive one source, then judge power state and latched source
    task automatic try_wake(input logic [3:0] c, input logic w);
        logic [3:0] prev;
        logic       was;
        prev = src;
        was = ps_on;
        set_src(c, 1'b1);
        cyc(6);
        set_src(c, 1'b0);
        cyc(4);
        chk_bit(ps_on, w | was, "power state after wake request");
        chk_vec(src, w ? c : prev, "latched wake source");
    endtask

    task automatic to_sleep(input logic deep, input logic by_switch);
        s4 = deep;
        set_src(SRC_PWRSW, by_switch);
        slp = ~by_switch;
        cyc(6);
        slp = 1'b0;
        set_src(SRC_PWRSW, 1'b0);
        cyc(4);
        chk_bit(ps_on, 1'b0, "supply still on in sleep");
        chk_vec({1'b0, fan_pwm}, 4'h0, "fans running in sleep");
        chk_bit(amber, ~deep & dual, "sleep indicator");
        chk_bit(green, 1'b0, "green indicator in sleep");
        chk_vec({1'b0, seen}, 4'h0, "tach flags outside working state");
    endtask

    task automatic long_off();
        pwr_sw_n = 1'b0;
        cyc(LONG + 6);
        chk_bit(ps_on, 1'b0, "long press while held");
        pwr_sw_n = 1'b1;
        cyc(6);
        chk_bit(ps_on, 1'b0, "long press after release");
    endtask

    task automatic count_low(input int n, output int lows);
        lows = 0;
        repeat (n)
        begin
            cyc(1);
            lows += int'(stby === 1'b0);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic sc_power_on();
        int lows;
        int hi;
        try_wake(SRC_PWRSW, 1'b1);
        chk_vec({1'b0, fan_pwm}, 4'h7, "fans in working state");
        chk_bit(green, 1'b1, "green indicator");
        // Quarter duty: high for 64 of every 256 cycles
        duty = 8'h40;
        cyc(2);
        hi = 0;
        repeat (256)
        begin
            cyc(1);
            hi += int'(fan_pwm[0] === 1'b1);
        end
        chk_bit(hi == 64, 1'b1, "fan duty cycle");
        duty = 8'hFF;
        cyc(2);
        boot = 1'b1;
        count_low(12, lows);
        chk_bit(lows > 0, 1'b1, "standby indicator blink");
        chk_vec({1'b0, seen}, 4'h7, "tach feedback");
        video = 1'b1;
        cyc(4);
        count_low(12, lows);
        chk_bit(lows == 0, 1'b1, "standby indicator steady");
        // Drop boot first so a stale boot level cannot restart the blink
        boot = 1'b0;
        cyc(4);
        video = 1'b0;
    endtask

    task automatic sc_sleep_wakes();
        try_wake(SRC_USB, 1'b0);
        try_wake(SRC_WAKE, 1'b0);
        dual = 1'b0;
        to_sleep(1'b0, 1'b1);
        set_src(SRC_USB, 1'b1);
        try_wake(SRC_LAN, 1'b1);
        set_src(SRC_USB, 1'b0);
        // Let the USB level clear the synchroniser before sleeping
        cyc(4);
        dual = 1'b1;
        to_sleep(1'b0, 1'b0);
        try_wake(SRC_USB, 1'b1);
        to_sleep(1'b0, 1'b0);
        try_wake(SRC_SER, 1'b1);
        to_sleep(1'b0, 1'b0);
        try_wake(SRC_KBD, 1'b1);
        to_sleep(1'b1, 1'b0);
        try_wake(SRC_USB, 1'b0);
        try_wake(SRC_SER, 1'b0);
        try_wake(SRC_KBD, 1'b0);
        try_wake(SRC_PME, 1'b0);
        pme_en = 1'b1;
        try_wake(SRC_PME, 1'b1);
        to_sleep(1'b1, 1'b0);
        kbd_key = 1'b1;
        try_wake(SRC_KBD, 1'b1);
        kbd_key = 1'b0;
    endtask

    task automatic sc_soft_off();
        long_off();
        try_wake(SRC_RTC, 1'b0);
        rtc_armed = 1'b1;
        try_wake(SRC_RTC, 1'b1);
        long_off();
        try_wake(SRC_WAKE, 1'b1);
        long_off();
        try_wake(SRC_PME, 1'b1);
    endtask

    task automatic sc_fault();
        fault = 1'b1;
        cyc(4);
        chk_bit(ps_on, 1'b0, "supply after rail fault");
        chk_bit(red, 1'b1, "warning indicator");
        fault = 1'b0;
        cyc(2);
        try_wake(SRC_PWRSW, 1'b1);
        chk_bit(rec, 1'b1, "fault record after power-on");
        fclr = 1'b1;
        cyc(1);
        fclr = 1'b0;
        cyc(2);
        chk_bit(rec, 1'b0, "fault record cleared");
    endtask

    initial
    begin
        cyc(10);
        rst = 1'b0;
        cyc(2);
        chk_bit(ps_on, 1'b0, "supply after reset");
        chk_bit(stby, 1'b1, "standby indicator");
        sc_power_on();
        sc_sleep_wakes();
        sc_soft_off();
        sc_fault();
        give_verdict();
    end

    initial
    begin
        #(4000 * 50);
        err_total++;
        give_verdict();
    end
endmodule
